// [rtl/tmc_pkg.sv]
// Constants, register map and types for the dual timer/counter
package tmc_pkg;

    // ****************************************
    // Clocking
    // ****************************************
    localparam int unsigned CLK_MHZ = 200;
    // Reference clock periods in one machine cycle
    localparam int unsigned OSC_PER_MC = 12;
    localparam logic [3:0] MC_DIV_LAST = 4'(OSC_PER_MC - 1);

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned ADDR_W = 3;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_MODE = 3'h1;
    localparam logic [2:0] REG_A_LOW = 3'h2;
    localparam logic [2:0] REG_A_HIGH = 3'h3;
    localparam logic [2:0] REG_B_LOW = 3'h4;
    localparam logic [2:0] REG_B_HIGH = 3'h5;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int unsigned B_OVF = 7;
    localparam int unsigned B_RUN = 6;
    localparam int unsigned A_OVF = 5;
    localparam int unsigned A_RUN = 4;
    localparam int unsigned B_EDGE = 3;
    localparam int unsigned B_TYPE = 2;
    localparam int unsigned A_EDGE = 1;
    localparam int unsigned A_TYPE = 0;

    // ****************************************
    // Mode register fields
    // ****************************************
    localparam int unsigned CFG_B_LSB = 4;
    localparam int unsigned CFG_A_LSB = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [3:0] DIV_RST = 4'h0;

    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_RELOAD8,
        MODE_SPLIT
    } tmc_mode_e;

    // One nibble of the mode register: gate bit, function bit, mode field
    typedef struct packed {
        logic gate;
        logic ext_count;
        tmc_mode_e mode;
    } tmc_cfg_s;

endpackage : tmc_pkg

// [rtl/tmc_dual_timer.sv]
// Dual timer/counter with control, mode and count registers
// Notes on behaviour
// - Overflow sets flag; interrupt vector clears it
// - Run bits switch each timer on/off
// - External edge flags set on edge, cleared on service
// - Type bits pick edge or level interrupt
// - Mode 0: 13 bits, low five prescale
// - Mode 0 upper low-byte bits undefined, ignored
// - Count only when run and gate allows
// - Rollover to zero sets the overflow flag
// - Setting run bit keeps count values
// - Mode 1: cascaded 16-bit counter, no prescaler
// - Mode 2: low byte reloads from high byte
// - Timer B in mode 3 holds count
// - Timer A mode 3 low byte uses A controls
// - Timer A mode 3 high byte uses B run/flag
// - B still runs, overflows without setting flag
// - Function bit picks machine cycles or pin
// - Mode upper nibble B, lower nibble A
// - Timer increments once per machine cycle
// - Counter counts sampled high-then-low on pin
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps

// ****************************************
// Count register pair for one timer
// ****************************************
module tmc_counter #(
    parameter bit SPLIT_OK = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic inc_i,
    input wire logic inc_high_i,
    input tmc_pkg::tmc_mode_e mode_i,
    input wire logic wr_low_i,
    input wire logic wr_high_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] low_o,
    output logic [7:0] high_o,
    output logic ovf_o,
    output logic ovf_high_o
);
    logic [7:0] low_next;
    logic [7:0] high_next;
    logic ovf_next;
    logic ovf_high_next;

    always_comb begin
        low_next = low_o;
        high_next = high_o;
        ovf_next = 1'b0;
        ovf_high_next = 1'b0;
        case (mode_i)
            tmc_pkg::MODE_13BIT: begin
                // Bits 7:5 of the low byte are left as they are
                if (inc_i) begin
                    if (low_o[4:0] == 5'h1f) begin
                        low_next = {low_o[7:5], 5'h00};
                        high_next = high_o + 8'h01;
                        ovf_next = (high_o == 8'hff);
                    end else begin
                        low_next = {low_o[7:5], low_o[4:0] + 5'h01};
                    end
                end
            end
            tmc_pkg::MODE_16BIT: begin
                if (inc_i) begin
                    {high_next, low_next} = {high_o, low_o} + 16'h0001;
                    ovf_next = ({high_o, low_o} == 16'hffff);
                end
            end
            tmc_pkg::MODE_RELOAD8: begin
                if (inc_i) begin
                    if (low_o == 8'hff) begin
                        low_next = high_o;
                        ovf_next = 1'b1;
                    end else begin
                        low_next = low_o + 8'h01;
                    end
                end
            end
            tmc_pkg::MODE_SPLIT: begin
                if (SPLIT_OK) begin
                    if (inc_i) begin
                        low_next = low_o + 8'h01;
                        ovf_next = (low_o == 8'hff);
                    end
                    if (inc_high_i) begin
                        high_next = high_o + 8'h01;
                        ovf_high_next = (high_o == 8'hff);
                    end
                end
            end
            default: begin
                low_next = low_o;
            end
        endcase
        if (wr_low_i) begin
            low_next = wdata_i;
        end
        if (wr_high_i) begin
            high_next = wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            low_o <= tmc_pkg::COUNT_RST;
            high_o <= tmc_pkg::COUNT_RST;
            ovf_o <= 1'b0;
            ovf_high_o <= 1'b0;
        end else begin
            low_o <= low_next;
            high_o <= high_next;
            ovf_o <= ovf_next;
            ovf_high_o <= ovf_high_next;
        end
    end
endmodule : tmc_counter

// ****************************************
// Top level
// ****************************************
module tmc_dual_timer (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic timer_a_count_pin_i,
    input wire logic timer_b_count_pin_i,
    input wire logic ext_irq_a_pin_i,
    input wire logic ext_irq_b_pin_i,
    input wire logic timer_a_vector_ack_i,
    input wire logic timer_b_vector_ack_i,
    input wire logic ext_irq_a_ack_i,
    input wire logic ext_irq_b_ack_i,
    output logic [7:0] ctrl_o,
    output logic timer_a_ovf_o,
    output logic timer_b_ovf_o
);
    logic [7:0] ctrl_reg;
    logic [7:0] mode_reg;
    logic [7:0] rdata_reg;
    logic [3:0] div_reg;
    logic tick_reg;
    logic cnt_a_smp_reg;
    logic cnt_b_smp_reg;
    logic irq_a_smp_reg;
    logic irq_b_smp_reg;
    logic [7:0] a_low;
    logic [7:0] a_high;
    logic [7:0] b_low;
    logic [7:0] b_high;
    logic a_ovf;
    logic a_ovf_high;
    logic b_ovf;
    tmc_pkg::tmc_cfg_s cfg_a;
    tmc_pkg::tmc_cfg_s cfg_b;
    logic wr_ctrl;
    logic fall_a;
    logic fall_b;
    logic irq_fall_a;
    logic irq_fall_b;
    logic inc_a;
    logic inc_b;
    logic inc_a_high;
    logic a_split;
    logic b_flag_set;

    assign cfg_a = tmc_pkg::tmc_cfg_s'(mode_reg[tmc_pkg::CFG_A_LSB +: 4]);
    assign cfg_b = tmc_pkg::tmc_cfg_s'(mode_reg[tmc_pkg::CFG_B_LSB +: 4]);
    assign wr_ctrl = wr_i && (addr_i == tmc_pkg::REG_CTRL);
    assign a_split = (cfg_a.mode == tmc_pkg::MODE_SPLIT);

    // ****************************************
    // Machine cycle tick
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            div_reg <= tmc_pkg::DIV_RST;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= (div_reg == tmc_pkg::MC_DIV_LAST) ? tmc_pkg::DIV_RST : div_reg + 4'h1;
            tick_reg <= (div_reg == tmc_pkg::MC_DIV_LAST);
        end
    end

    // ****************************************
    // Pin sampling, once per machine cycle
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cnt_a_smp_reg <= 1'b0;
            cnt_b_smp_reg <= 1'b0;
            irq_a_smp_reg <= 1'b1;
            irq_b_smp_reg <= 1'b1;
        end else if (tick_reg) begin
            cnt_a_smp_reg <= timer_a_count_pin_i;
            cnt_b_smp_reg <= timer_b_count_pin_i;
            irq_a_smp_reg <= ext_irq_a_pin_i;
            irq_b_smp_reg <= ext_irq_b_pin_i;
        end
    end

    assign fall_a = tick_reg && cnt_a_smp_reg && !timer_a_count_pin_i;
    assign fall_b = tick_reg && cnt_b_smp_reg && !timer_b_count_pin_i;
    assign irq_fall_a = tick_reg && irq_a_smp_reg && !ext_irq_a_pin_i;
    assign irq_fall_b = tick_reg && irq_b_smp_reg && !ext_irq_b_pin_i;

    // ****************************************
    // Count enables
    // ****************************************
    assign inc_a = ctrl_reg[tmc_pkg::A_RUN] && (!cfg_a.gate || ext_irq_a_pin_i)
        && (cfg_a.ext_count ? fall_a : tick_reg);
    assign inc_b = ctrl_reg[tmc_pkg::B_RUN] && (!cfg_b.gate || ext_irq_b_pin_i)
        && (cfg_b.ext_count ? fall_b : tick_reg);
    assign inc_a_high = tick_reg && ctrl_reg[tmc_pkg::B_RUN];
    // Split timer A takes the B flag; B overflows then only pulse the output
    assign b_flag_set = a_split ? a_ovf_high : b_ovf;

    tmc_counter #(
        .SPLIT_OK(1'b1)
    ) u_timer_a (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .inc_i(inc_a),
        .inc_high_i(inc_a_high),
        .mode_i(cfg_a.mode),
        .wr_low_i(wr_i && (addr_i == tmc_pkg::REG_A_LOW)),
        .wr_high_i(wr_i && (addr_i == tmc_pkg::REG_A_HIGH)),
        .wdata_i(wdata_i),
        .low_o(a_low),
        .high_o(a_high),
        .ovf_o(a_ovf),
        .ovf_high_o(a_ovf_high)
    );

    // Timer B in mode 3 holds as if stopped
    tmc_counter #(
        .SPLIT_OK(1'b0)
    ) u_timer_b (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .inc_i(inc_b),
        .inc_high_i(1'b0),
        .mode_i(cfg_b.mode),
        .wr_low_i(wr_i && (addr_i == tmc_pkg::REG_B_LOW)),
        .wr_high_i(wr_i && (addr_i == tmc_pkg::REG_B_HIGH)),
        .wdata_i(wdata_i),
        .low_o(b_low),
        .high_o(b_high),
        .ovf_o(b_ovf),
        .ovf_high_o()
    );

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ctrl_reg <= tmc_pkg::CTRL_RST;
        end else begin
            // Run and type bits only change on a write
            if (wr_ctrl) begin
                ctrl_reg[tmc_pkg::B_RUN] <= wdata_i[tmc_pkg::B_RUN];
                ctrl_reg[tmc_pkg::A_RUN] <= wdata_i[tmc_pkg::A_RUN];
                ctrl_reg[tmc_pkg::B_TYPE] <= wdata_i[tmc_pkg::B_TYPE];
                ctrl_reg[tmc_pkg::A_TYPE] <= wdata_i[tmc_pkg::A_TYPE];
            end
            // Hardware set wins over vector clear and software write
            if (a_ovf) begin
                ctrl_reg[tmc_pkg::A_OVF] <= 1'b1;
            end else if (timer_a_vector_ack_i) begin
                ctrl_reg[tmc_pkg::A_OVF] <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_reg[tmc_pkg::A_OVF] <= wdata_i[tmc_pkg::A_OVF];
            end
            if (b_flag_set) begin
                ctrl_reg[tmc_pkg::B_OVF] <= 1'b1;
            end else if (timer_b_vector_ack_i) begin
                ctrl_reg[tmc_pkg::B_OVF] <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_reg[tmc_pkg::B_OVF] <= wdata_i[tmc_pkg::B_OVF];
            end
            // Edge type: set on a sampled fall; level type: follows sampled low
            if (ctrl_reg[tmc_pkg::A_TYPE] ? irq_fall_a : (tick_reg && !ext_irq_a_pin_i)) begin
                ctrl_reg[tmc_pkg::A_EDGE] <= 1'b1;
            end else if (!ctrl_reg[tmc_pkg::A_TYPE] && tick_reg) begin
                ctrl_reg[tmc_pkg::A_EDGE] <= 1'b0;
            end else if (ext_irq_a_ack_i) begin
                ctrl_reg[tmc_pkg::A_EDGE] <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_reg[tmc_pkg::A_EDGE] <= wdata_i[tmc_pkg::A_EDGE];
            end
            if (ctrl_reg[tmc_pkg::B_TYPE] ? irq_fall_b : (tick_reg && !ext_irq_b_pin_i)) begin
                ctrl_reg[tmc_pkg::B_EDGE] <= 1'b1;
            end else if (!ctrl_reg[tmc_pkg::B_TYPE] && tick_reg) begin
                ctrl_reg[tmc_pkg::B_EDGE] <= 1'b0;
            end else if (ext_irq_b_ack_i) begin
                ctrl_reg[tmc_pkg::B_EDGE] <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_reg[tmc_pkg::B_EDGE] <= wdata_i[tmc_pkg::B_EDGE];
            end
        end
    end

    // ****************************************
    // Mode register and read port
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            mode_reg <= tmc_pkg::MODE_RST;
        end else if (wr_i && (addr_i == tmc_pkg::REG_MODE)) begin
            mode_reg <= wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rdata_reg <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                tmc_pkg::REG_CTRL: rdata_reg <= ctrl_reg;
                tmc_pkg::REG_MODE: rdata_reg <= mode_reg;
                tmc_pkg::REG_A_LOW: rdata_reg <= a_low;
                tmc_pkg::REG_A_HIGH: rdata_reg <= a_high;
                tmc_pkg::REG_B_LOW: rdata_reg <= b_low;
                tmc_pkg::REG_B_HIGH: rdata_reg <= b_high;
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign rdata_o = rdata_reg;
    assign ctrl_o = ctrl_reg;
    assign timer_a_ovf_o = a_ovf;
    assign timer_b_ovf_o = b_ovf;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    a_ovf_flag_set: assert property (a_ovf |=> ctrl_reg[tmc_pkg::A_OVF])
        else $error("timer A overflow did not set its flag");
    a_vector_clear: assert property (timer_a_vector_ack_i && !a_ovf
        |=> !ctrl_reg[tmc_pkg::A_OVF])
        else $error("vector ack did not clear timer A flag");
    a_stop_holds: assert property (!ctrl_reg[tmc_pkg::A_RUN]
        && !(wr_i && (addr_i == tmc_pkg::REG_A_LOW)) |=> $stable(a_low))
        else $error("stopped timer A changed");
    a_gate_blocks: assert property (cfg_a.gate && !ext_irq_a_pin_i
        && !(wr_i && (addr_i == tmc_pkg::REG_A_LOW)) |=> $stable(a_low))
        else $error("gated timer A counted");
    a_tick_period: assert property (tick_reg |-> ##12 tick_reg)
        else $error("machine cycle is not twelve clocks");
    a_tick_single: assert property (tick_reg |=> !tick_reg [*8])
        else $error("machine tick repeated early");
    a_reload_value: assert property (inc_a && cfg_a.mode == tmc_pkg::MODE_RELOAD8
        && a_low == 8'hff && !wr_i |=> a_low == $past(a_high) && $stable(a_high))
        else $error("reload did not copy high byte");
    a_b_split_hold: assert property (cfg_b.mode == tmc_pkg::MODE_SPLIT && !wr_i
        |=> $stable({b_high, b_low}))
        else $error("timer B moved in mode 3");
    a_split_b_flag: assert property (a_split && a_ovf_high
        |=> ctrl_reg[tmc_pkg::B_OVF])
        else $error("split high byte did not set B flag");
    a_split_b_quiet: assert property (a_split && b_ovf && !a_ovf_high && !wr_i
        && !ctrl_reg[tmc_pkg::B_OVF] |=> !ctrl_reg[tmc_pkg::B_OVF])
        else $error("timer B overflow raised flag in split");
    a_run_keeps: assert property (wr_ctrl && !ctrl_reg[tmc_pkg::A_RUN]
        && wdata_i[tmc_pkg::A_RUN] |=> $stable(a_low) && $stable(a_high))
        else $error("starting timer A changed its count");
    a_edge_set: assert property (irq_fall_a && ctrl_reg[tmc_pkg::A_TYPE]
        |=> ctrl_reg[tmc_pkg::A_EDGE])
        else $error("falling edge did not set edge flag");
    a_pin_count: assert property (cfg_a.ext_count && cfg_a.mode == tmc_pkg::MODE_16BIT
        && inc_a && a_low != 8'hff && !wr_i |=> a_low == 8'($past(a_low) + 8'h01))
        else $error("pin fall did not advance timer A");
    a_prescale_carry: assert property (inc_a && cfg_a.mode == tmc_pkg::MODE_13BIT
        && a_low[4:0] == 5'h1f && !wr_i |=> a_high == 8'($past(a_high) + 8'h01))
        else $error("prescaler carry missing");
    a_cascade_carry: assert property (inc_a && cfg_a.mode == tmc_pkg::MODE_16BIT
        && a_low == 8'hff && !wr_i |=> a_high == 8'($past(a_high) + 8'h01))
        else $error("16-bit carry missing");
    a_mode_read: assert property (rd_i && addr_i == tmc_pkg::REG_MODE
        |=> rdata_o == $past(mode_reg))
        else $error("mode register read wrong");

    c_a_overflow: cover property (a_ovf ##1 ctrl_reg[tmc_pkg::A_OVF]);
    c_reload: cover property (inc_a && cfg_a.mode == tmc_pkg::MODE_RELOAD8 && a_low == 8'hff);
    c_split_high: cover property (a_split && a_ovf_high);
    c_edge_flag: cover property (irq_fall_b && ctrl_reg[tmc_pkg::B_TYPE]);
endmodule : tmc_dual_timer

// [verification/tmc_pin_model.sv]
// External pin model: count pins and interrupt pins facing the timers
`timescale 1ns/100ps

module tmc_pin_model (
    input wire logic ref_clk_i,
    output logic timer_a_count_pin_o,
    output logic timer_b_count_pin_o,
    output logic ext_irq_a_pin_o,
    output logic ext_irq_b_pin_o
);
    // ****************************************
    // Pin drivers
    // ****************************************
    // Pins rest high, as the port pull-ups leave them
    initial begin
        timer_a_count_pin_o = 1'b1;
        timer_b_count_pin_o = 1'b1;
        ext_irq_a_pin_o = 1'b1;
        ext_irq_b_pin_o = 1'b1;
    end

    // Falling edges on one count pin, each level held hold_mc machine cycles
    task automatic count_pulses(input bit sel_b, input int n, input int hold_mc);
        for (int i = 0; i < n; i++) begin
            repeat (tmc_pkg::OSC_PER_MC * hold_mc) @(posedge ref_clk_i);
            if (sel_b) timer_b_count_pin_o <= 1'b0;
            else timer_a_count_pin_o <= 1'b0;
            repeat (tmc_pkg::OSC_PER_MC * hold_mc) @(posedge ref_clk_i);
            if (sel_b) timer_b_count_pin_o <= 1'b1;
            else timer_a_count_pin_o <= 1'b1;
        end
    endtask : count_pulses

    task automatic set_irq(input bit sel_b, input logic level);
        @(posedge ref_clk_i);
        if (sel_b) ext_irq_b_pin_o <= level;
        else ext_irq_a_pin_o <= level;
    endtask : set_irq
endmodule : tmc_pin_model

// [verification/test_dual_timer_counter_modes.sv]
// Self-checking bench for the dual timer/counter
`timescale 1ns/100ps

module test_dual_timer_counter_modes;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] ack = 4'h0;
    logic [7:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] seen;
    logic pa, pb, ia, ib, ovf_a, ovf_b;
    int error_cnt = 0;
    int compares = 0;
    int n_ovf_b = 0;
    int n_ovf_a = 0;

    always #2.5 clk = ~clk;

    tmc_dual_timer u_tmc_dual_timer (
        .ref_clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .timer_a_count_pin_i(pa), .timer_b_count_pin_i(pb),
        .ext_irq_a_pin_i(ia), .ext_irq_b_pin_i(ib),
        .timer_a_vector_ack_i(ack[0]), .timer_b_vector_ack_i(ack[1]),
        .ext_irq_a_ack_i(ack[2]), .ext_irq_b_ack_i(ack[3]),
        .ctrl_o(ctrl), .timer_a_ovf_o(ovf_a), .timer_b_ovf_o(ovf_b)
    );

    tmc_pin_model u_tmc_pin_model (
        .ref_clk_i(clk), .timer_a_count_pin_o(pa), .timer_b_count_pin_o(pb),
        .ext_irq_a_pin_o(ia), .ext_irq_b_pin_o(ib)
    );

    always @(posedge clk) begin
        if (ovf_b === 1'b1) n_ovf_b++;
        if (ovf_a === 1'b1) n_ovf_a++;
    end

    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
        compares++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask : check

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] want, input logic [7:0] m,
                          input string what);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata & m, want & m, what);
        @(posedge clk);
    endtask : rd_chk

    task automatic pulse_ack(input int i);
        ack[i] <= 1'b1;
        @(posedge clk);
        ack[i] <= 1'b0;
        @(posedge clk);
    endtask : pulse_ack

    // Run bits high for exactly n machine cycles; flags kept on stop
    task automatic run_ticks(input int n, input logic [7:0] runv);
        wr_reg(tmc_pkg::REG_CTRL, runv);
        repeat (tmc_pkg::OSC_PER_MC * n - 3) @(posedge clk);
        #1;
        seen = ctrl;
        @(posedge clk);
        wr_reg(tmc_pkg::REG_CTRL, seen & 8'haf);
    endtask : run_ticks

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            rd_chk(3'(i), 8'h00, 8'hff, "reset value");
        end
        wr_reg(3'h6, 8'hff);
        rd_chk(3'h6, 8'h00, 8'hff, "unmapped read");
        wr_reg(tmc_pkg::REG_MODE, 8'h5a);
        rd_chk(tmc_pkg::REG_MODE, 8'h5a, 8'hff, "mode readback");
    endtask : t_regs

    task automatic t_rate();
        wr_reg(tmc_pkg::REG_MODE, 8'h01);
        run_ticks(20, 8'h10);
        rd_chk(tmc_pkg::REG_A_LOW, 8'h14, 8'hff, "16-bit count");
        wr_reg(tmc_pkg::REG_MODE, 8'h00);
        wr_reg(tmc_pkg::REG_A_LOW, 8'h1e);
        run_ticks(3, 8'h10);
        rd_chk(tmc_pkg::REG_A_LOW, 8'h01, 8'h1f, "prescaler");
        rd_chk(tmc_pkg::REG_A_HIGH, 8'h01, 8'hff, "13-bit high");
    endtask : t_rate

    task automatic t_gate();
        wr_reg(tmc_pkg::REG_MODE, 8'h09);
        wr_reg(tmc_pkg::REG_A_LOW, 8'hf8);
        u_tmc_pin_model.set_irq(1'b0, 1'b0);
        run_ticks(10, 8'h10);
        check(seen & 8'h02, 8'h02, "level flag");
        rd_chk(tmc_pkg::REG_A_LOW, 8'hf8, 8'hff, "gated hold");
        u_tmc_pin_model.set_irq(1'b0, 1'b1);
        run_ticks(10, 8'h10);
        rd_chk(tmc_pkg::REG_A_LOW, 8'h02, 8'hff, "gate open");
        rd_chk(tmc_pkg::REG_A_HIGH, 8'h02, 8'hff, "16-bit carry");
    endtask : t_gate

    task automatic t_reload();
        wr_reg(tmc_pkg::REG_MODE, 8'h02);
        wr_reg(tmc_pkg::REG_A_HIGH, 8'hf0);
        wr_reg(tmc_pkg::REG_A_LOW, 8'hfe);
        n_ovf_a = 0;
        run_ticks(3, 8'h10);
        check(seen & 8'h20, 8'h20, "overflow flag");
        check(8'(n_ovf_a), 8'h01, "A overflow pulse");
        rd_chk(tmc_pkg::REG_A_LOW, 8'hf1, 8'hff, "reload low");
        rd_chk(tmc_pkg::REG_A_HIGH, 8'hf0, 8'hff, "reload high");
        pulse_ack(0);
        rd_chk(tmc_pkg::REG_CTRL, 8'h00, 8'h20, "vector clear");
    endtask : t_reload

    task automatic t_counter();
        for (int s = 0; s < 2; s++) begin
            wr_reg(tmc_pkg::REG_MODE, s ? 8'h50 : 8'h05);
            wr_reg(s ? tmc_pkg::REG_B_LOW : tmc_pkg::REG_A_LOW, 8'h00);
            wr_reg(tmc_pkg::REG_CTRL, s ? 8'h40 : 8'h10);
            u_tmc_pin_model.count_pulses(s[0], 4, 2 - s);
            repeat (36) @(posedge clk);
            wr_reg(tmc_pkg::REG_CTRL, 8'h00);
            rd_chk(s ? tmc_pkg::REG_B_LOW : tmc_pkg::REG_A_LOW, 8'h04, 8'hff, "events");
        end
    endtask : t_counter

    task automatic t_ext_edge();
        for (int s = 0; s < 2; s++) begin
            wr_reg(tmc_pkg::REG_CTRL, s ? 8'h04 : 8'h01);
            u_tmc_pin_model.set_irq(s[0], 1'b0);
            repeat (36) @(posedge clk);
            u_tmc_pin_model.set_irq(s[0], 1'b1);
            repeat (36) @(posedge clk);
            rd_chk(tmc_pkg::REG_CTRL, 8'hff, s ? 8'h08 : 8'h02, "edge flag");
            pulse_ack(2 + s);
            rd_chk(tmc_pkg::REG_CTRL, 8'h00, s ? 8'h08 : 8'h02, "edge cleared");
        end
        wr_reg(tmc_pkg::REG_CTRL, 8'h00);
    endtask : t_ext_edge

    task automatic t_split();
        wr_reg(tmc_pkg::REG_MODE, 8'h30);
        wr_reg(tmc_pkg::REG_B_LOW, 8'h05);
        run_ticks(5, 8'h40);
        rd_chk(tmc_pkg::REG_B_LOW, 8'h05, 8'hff, "B mode 3 hold");
        wr_reg(tmc_pkg::REG_MODE, 8'h13);
        wr_reg(tmc_pkg::REG_A_LOW, 8'hfe);
        wr_reg(tmc_pkg::REG_A_HIGH, 8'h00);
        wr_reg(tmc_pkg::REG_B_LOW, 8'hfe);
        wr_reg(tmc_pkg::REG_B_HIGH, 8'hff);
        n_ovf_b = 0;
        n_ovf_a = 0;
        run_ticks(3, 8'h50);
        check(seen & 8'ha0, 8'h20, "split flags");
        check(8'(n_ovf_a), 8'h01, "split low pulse");
        check(8'(n_ovf_b), 8'h01, "B overflow pulse");
        rd_chk(tmc_pkg::REG_A_LOW, 8'h01, 8'hff, "split low");
        rd_chk(tmc_pkg::REG_A_HIGH, 8'h03, 8'hff, "split high");
        wr_reg(tmc_pkg::REG_CTRL, 8'h00);
        wr_reg(tmc_pkg::REG_A_HIGH, 8'hfe);
        run_ticks(3, 8'h40);
        check(seen & 8'h80, 8'h80, "high byte flag");
        pulse_ack(1);
        rd_chk(tmc_pkg::REG_CTRL, 8'h00, 8'h80, "B vector clear");
    endtask : t_split

    // ****************************************
    // Verdict, watchdog and main sequence
    // ****************************************
    task automatic tally_and_finish();
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_rate();
        t_gate();
        t_reload();
        t_counter();
        t_ext_edge();
        t_split();
        tally_and_finish();
    end
endmodule : test_dual_timer_counter_modes
